// ---- shared/rdec_defs.svh ----
`ifndef RDEC_DEFS_SVH
`define RDEC_DEFS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RDEC_CLK_HZ 200000000
`define RDEC_MIN_BAUD 1200
`define RDEC_FRAME_BITS 10
// longest bit time at the slowest rate, rounded down to whole cycles
`define RDEC_MAX_BIT_CYCLES (`RDEC_CLK_HZ / `RDEC_MIN_BAUD)
`define RDEC_CNT_W 24
`define RDEC_SETTLE_CYCLES 4

// ----------------------------------------------------------------------------
// buffering
// ----------------------------------------------------------------------------
`define RDEC_FIFO_DEPTH 32

// ----------------------------------------------------------------------------
// pin vector width and reset value
// ----------------------------------------------------------------------------
`define RDEC_PIN_W 7
`define RDEC_PIN_RESET 7'h43

`endif

// ---- shared/rdec_pkg.sv ----
`default_nettype none
package rdec_pkg;

    // ------------------------------------------------------------------------
    // control modes selected by the mode switch
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        RDEC_MODE_ALWAYS = 2'b00,
        RDEC_MODE_AUTO = 2'b01,
        RDEC_MODE_RTS = 2'b10,
        RDEC_MODE_DATA = 2'b11
    } rdec_mode_t;

    // ------------------------------------------------------------------------
    // synchronised pin group
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic tx;
        logic rts;
        logic rx_pos;
        logic rx_neg;
        logic echo_off;
        logic [1:0] mode;
    } rdec_pins_t;

endpackage
`default_nettype wire

// ---- hw/rdec_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module rdec_fifo
    import rdec_pkg::*;
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else if (ce)
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk)
    begin
        if (ce && push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ---- hw/rdec_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rdec_defs.svh"
module rdec_top
    import rdec_pkg::*;
#(
    parameter int MAX_BIT_CYCLES = `RDEC_MAX_BIT_CYCLES,
    parameter int FIFO_DEPTH = `RDEC_FIFO_DEPTH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // switches
    input wire logic [1:0] mode_select_switch,
    input wire logic line_option_switch,
    // host side
    input wire logic host_transmit_in,
    input wire logic host_request_in,
    output logic host_receive_out,
    // bus side
    output logic bus_tx_positive,
    output logic bus_tx_negative,
    output logic bus_tx_oe,
    input wire logic bus_rx_positive,
    input wire logic bus_rx_negative,
    // indicator
    output logic enable_led
);
    localparam int CW = `RDEC_CNT_W;
    localparam logic [CW-1:0] MAX_BIT = CW'(MAX_BIT_CYCLES);
    localparam logic [CW-1:0] FRAME = CW'(`RDEC_FRAME_BITS);
    localparam logic [2:0] SETTLE = 3'(`RDEC_SETTLE_CYCLES);

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    rdec_pins_t raw;
    rdec_pins_t s1;
    rdec_pins_t s2;
    rdec_pins_t s3;
    rdec_pins_t pins;
    rdec_pins_t next_pins;

    assign raw = '{tx: host_transmit_in, rts: host_request_in, rx_pos: bus_rx_positive,
                   rx_neg: bus_rx_negative, echo_off: line_option_switch, mode: mode_select_switch};

    // each bit is accepted once the second and third stage agree
    genvar gi;
    generate
        for (gi = 0; gi < `RDEC_PIN_W; gi++)
        begin : g_sync
            always_comb
            begin
                next_pins[gi] = (s2[gi] == s3[gi]) ? s2[gi] : pins[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1 <= `RDEC_PIN_RESET;
            s2 <= `RDEC_PIN_RESET;
            s3 <= `RDEC_PIN_RESET;
            pins <= `RDEC_PIN_RESET;
        end
        else if (ce)
        begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            pins <= next_pins;
        end
    end

    // ------------------------------------------------------------------------
    // one-time mode latch
    // ------------------------------------------------------------------------
    logic [2:0] settle;
    logic latched;
    rdec_mode_t mode;
    logic [2:0] next_settle;
    logic next_latched;
    rdec_mode_t next_mode;

    always_comb
    begin
        next_settle = settle;
        next_latched = latched;
        next_mode = mode;
        if (!latched)
        begin
            if (settle == SETTLE)
            begin
                next_latched = 1'b1;
                next_mode = rdec_mode_t'(pins.mode);
            end
            else
            begin
                next_settle = settle + 3'h1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            settle <= 3'h0;
            latched <= 1'b0;
            mode <= RDEC_MODE_ALWAYS;
        end
        else if (ce)
        begin
            settle <= next_settle;
            latched <= next_latched;
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------------------
    // edge interval measurement
    // ------------------------------------------------------------------------
    logic tx_prev;
    logic [CW-1:0] interval;
    logic pend_valid;
    logic [CW-1:0] pend_data;
    logic next_tx_prev;
    logic [CW-1:0] next_interval;
    logic next_pend_valid;
    logic [CW-1:0] next_pend_data;
    logic tx_edge;
    logic tx_fall;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [CW-1:0] fifo_out_data;
    logic pop_phase;

    assign tx_edge = pins.tx ^ tx_prev;
    assign tx_fall = tx_prev && !pins.tx;

    always_comb
    begin
        next_tx_prev = pins.tx;
        next_interval = (interval == MAX_BIT) ? interval : interval + 1'b1;
        next_pend_valid = pend_valid && !fifo_in_ready;
        next_pend_data = pend_data;
        if (tx_edge)
        begin
            next_interval = CW'(1);
            // a full buffer drops the new interval, never stalls the sampling
            if (!pend_valid || fifo_in_ready)
            begin
                next_pend_valid = 1'b1;
                next_pend_data = interval;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_prev <= 1'b1;
            interval <= MAX_BIT;
            pend_valid <= 1'b0;
            pend_data <= '0;
        end
        else if (ce)
        begin
            tx_prev <= next_tx_prev;
            interval <= next_interval;
            pend_valid <= next_pend_valid;
            pend_data <= next_pend_data;
        end
    end

    rdec_fifo #(
        .WIDTH(CW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_valid(pend_valid),
        .in_ready(fifo_in_ready),
        .in_data(pend_data),
        .out_valid(fifo_out_valid),
        .out_ready(pop_phase),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------------------
    // rate estimate and hold timer
    // ------------------------------------------------------------------------
    logic [CW-1:0] period;
    logic [CW-1:0] hold;
    logic [CW-1:0] next_period;
    logic [CW-1:0] next_hold;
    logic next_pop_phase;

    always_comb
    begin
        next_pop_phase = !pop_phase;
        next_period = period;
        // shortest edge spacing seen is one bit time
        if (pop_phase && fifo_out_valid && fifo_out_data != '0 && fifo_out_data < period)
        begin
            next_period = fifo_out_data;
        end
        next_hold = (hold != '0) ? hold - 1'b1 : hold;
        if (mode == RDEC_MODE_AUTO && tx_fall)
        begin
            next_hold = CW'(period * FRAME);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            period <= MAX_BIT;
            hold <= '0;
            pop_phase <= 1'b0;
        end
        else if (ce)
        begin
            period <= next_period;
            hold <= next_hold;
            pop_phase <= next_pop_phase;
        end
    end

    // ------------------------------------------------------------------------
    // driver enable and outputs
    // ------------------------------------------------------------------------
    logic rx_level;
    logic next_oe;
    logic next_rx_level;
    logic next_receive;

    always_comb
    begin
        next_oe = 1'b0;
        if (latched)
        begin
            case (mode)
                RDEC_MODE_ALWAYS: next_oe = 1'b1;
                RDEC_MODE_AUTO: next_oe = tx_fall || (hold != '0) || !pins.tx;
                RDEC_MODE_RTS: next_oe = pins.rts;
                RDEC_MODE_DATA: next_oe = !pins.tx;
                default: next_oe = 1'b0;
            endcase
        end
        next_rx_level = (pins.rx_pos != pins.rx_neg) ? pins.rx_pos : rx_level;
        // idle mark returned while our own driver is on and echo_off is set
        next_receive = (pins.echo_off && next_oe) ? 1'b1 : next_rx_level;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_level <= 1'b1;
            bus_tx_oe <= 1'b0;
            enable_led <= 1'b0;
            bus_tx_positive <= 1'b1;
            bus_tx_negative <= 1'b0;
            host_receive_out <= 1'b1;
        end
        else if (ce)
        begin
            rx_level <= next_rx_level;
            bus_tx_oe <= next_oe;
            enable_led <= next_oe;
            bus_tx_positive <= pins.tx;
            bus_tx_negative <= !pins.tx;
            host_receive_out <= next_receive;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk iff ce);
    endclocking
    default disable iff (rst);

    property p_rts_follow;
        (latched && mode == RDEC_MODE_RTS) ##1 (latched && mode == RDEC_MODE_RTS) |-> bus_tx_oe == $past(pins.rts);
    endproperty
    a_rts_follow: assert property (p_rts_follow) else $error("oe does not follow request");

    property p_data_low;
        (latched && mode == RDEC_MODE_DATA && !pins.tx) |=> bus_tx_oe && !bus_tx_positive;
    endproperty
    a_data_low: assert property (p_data_low) else $error("data low did not enable");

    property p_data_high;
        (latched && mode == RDEC_MODE_DATA && pins.tx) |=> !bus_tx_oe;
    endproperty
    a_data_high: assert property (p_data_high) else $error("data high did not tri-state");

    property p_always_on;
        (latched && mode == RDEC_MODE_ALWAYS) |=> (bus_tx_oe && enable_led) [*3];
    endproperty
    a_always_on: assert property (p_always_on) else $error("always mode dropped enable");

    property p_mode_frozen;
        latched |=> latched && $stable(mode);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed after latch");

    property p_latch_time;
        $fell(rst) |-> ##[1:6] latched;
    endproperty
    a_latch_time: assert property (p_latch_time) else $error("mode not latched in time");

    property p_sample_always;
        (s2 == s3) |=> pins == $past(s2);
    endproperty
    a_sample_always: assert property (p_sample_always) else $error("sampling stalled");

    property p_no_echo;
        (pins.echo_off && next_oe) |=> host_receive_out && bus_tx_oe;
    endproperty
    a_no_echo: assert property (p_no_echo) else $error("echo not suppressed");

    property p_auto_start;
        (latched && mode == RDEC_MODE_AUTO && tx_fall) |=> bus_tx_oe && hold == CW'($past(period) * FRAME);
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("start bit did not arm hold");

    property p_auto_release;
        (latched && mode == RDEC_MODE_AUTO && hold == '0 && pins.tx && !tx_fall) |=> !bus_tx_oe;
    endproperty
    a_auto_release: assert property (p_auto_release) else $error("auto enable held too long");

    property p_rate_min;
        (pop_phase && fifo_out_valid && fifo_out_data != '0 && fifo_out_data < period)
            |=> period == $past(fifo_out_data) && period <= MAX_BIT;
    endproperty
    a_rate_min: assert property (p_rate_min) else $error("rate estimate not updated");

    c_auto_on: cover property (latched && mode == RDEC_MODE_AUTO ##1 $rose(bus_tx_oe));
    c_rts_on: cover property (latched && mode == RDEC_MODE_RTS && bus_tx_oe);
    c_data_toggle: cover property (mode == RDEC_MODE_DATA && $fell(bus_tx_oe));
    c_fifo_full: cover property (!fifo_in_ready);
endmodule
`default_nettype wire

// ---- bench/rdec_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rdec_host_model
#(
    parameter int BIT_CYCLES = 40
)
(
    // clock
    input wire logic clk,
    // host pins
    output logic tx,
    output logic rts,
    // remote bus node, biased idle when released
    output logic rx_pos,
    output logic rx_neg
);
    initial
    begin
        tx = 1'b1;
        rts = 1'b0;
        rx_pos = 1'b1;
        rx_neg = 1'b0;
    end

    task automatic drive_tx(input logic v);
        @(posedge clk);
        tx <= v;
    endtask

    task automatic drive_rts(input logic v);
        @(posedge clk);
        rts <= v;
    endtask

    task automatic set_rx(input logic v);
        @(posedge clk);
        rx_pos <= v;
        rx_neg <= ~v;
    endtask

    // both wires at one level: no valid difference on the pair
    task automatic tie_rx(input logic v);
        @(posedge clk);
        rx_pos <= v;
        rx_neg <= v;
    endtask

    // start bit, eight data bits lsb first, stop bit, at a fixed bit time
    task automatic send_char(input logic [7:0] d);
        logic [9:0] f;
        f = {1'h1, d, 1'h0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            tx <= f[i];
            repeat (BIT_CYCLES - 1) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_rdec_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_rdec_top
    import rdec_pkg::*;
;
    localparam int MAXB = 200;
    localparam int BITC = 40;
    logic clk = 1'h0;
    logic rst;
    logic ce;
    logic [1:0] mode_sw;
    logic echo_sw;
    logic tx, rts, rx_p, rx_n, host_rx, bus_p, bus_n, bus_oe, led;
    logic [7:0] seed = 8'h0b;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #2.5 clk = ~clk;

    rdec_top #(.MAX_BIT_CYCLES(MAXB)) u_dut (
        .clk(clk), .rst(rst), .ce(ce),
        .mode_select_switch(mode_sw), .line_option_switch(echo_sw),
        .host_transmit_in(tx), .host_request_in(rts), .host_receive_out(host_rx),
        .bus_tx_positive(bus_p), .bus_tx_negative(bus_n), .bus_tx_oe(bus_oe),
        .bus_rx_positive(rx_p), .bus_rx_negative(rx_n), .enable_led(led)
    );

    rdec_host_model #(.BIT_CYCLES(BITC)) u_host (
        .clk(clk), .tx(tx), .rts(rts), .rx_pos(rx_p), .rx_neg(rx_n)
    );

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [7:0] rnd(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // reference enable level for the always, request and data modes; auto mode is not modelled and returns 0
    function automatic int model_oe(input int m, input int t, input int r);
        if (m == int'(RDEC_MODE_ALWAYS))
            return 1;
        if (m == int'(RDEC_MODE_RTS))
            return r;
        if (m == int'(RDEC_MODE_DATA))
            return (t == 0) ? 1 : 0;
        return 0;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("counts: %0d checked, %0d mismatched", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // power cycle with a new switch setting, then move the switch
    task automatic power_up(input logic [1:0] m);
        @(posedge clk);
        rst <= 1'h1;
        mode_sw <= m;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        repeat (8) @(posedge clk);
        mode_sw <= ~m;
    endtask

    // old level for four edges after the pin edge, new level on the fifth
    task automatic settle(input logic old_oe, input logic new_oe, input logic t);
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(bus_oe, old_oe);
        @(posedge clk);
        @(negedge clk);
        check({led, bus_oe, bus_p, bus_n}, {new_oe, new_oe, t, ~t});
    endtask

    task automatic wait_oe_low(input int lim, output int n);
        n = 0;
        while (bus_oe !== 1'h0)
        begin
            @(negedge clk);
            n++;
            if (n == lim)
            begin
                n_mismatch++;
                $display("unexpected at %0t: wait seen %h expected %h", $time, bus_oe, 1'h0);
                stop_test();
            end
        end
    endtask

    // ------------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------------
    initial
    begin
        logic t;
        logic pt;
        logic r;
        logic pr;
        int cnt;
        rst <= 1'h1;
        ce <= 1'h1;
        mode_sw <= 2'h0;
        echo_sw <= 1'h0;
        power_up(RDEC_MODE_ALWAYS);
        for (int i = 0; i < 6; i++)
        begin
            seed = rnd(seed);
            t = seed[0];
            u_host.drive_tx(t);
            settle(1'h1, model_oe(RDEC_MODE_ALWAYS, t, 0) != 0, t);
        end
        u_host.drive_tx(1'h1);
        $display("test always done");

        power_up(RDEC_MODE_RTS);
        pr = 1'h0;
        for (int i = 0; i < 8; i++)
        begin
            seed = rnd(seed);
            r = seed[1];
            u_host.drive_rts(r);
            settle(pr, model_oe(RDEC_MODE_RTS, 1, r) != 0, 1'h1);
            pr = r;
        end
        u_host.drive_rts(1'h1);
        echo_sw <= 1'h1;
        u_host.set_rx(1'h0);
        repeat (8) @(posedge clk);
        @(negedge clk);
        check(host_rx, 1'h1);
        @(posedge clk);
        echo_sw <= 1'h0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        check(host_rx, 1'h0);
        // equal wire levels carry no data: the last received level stands
        u_host.tie_rx(1'h1);
        repeat (8) @(posedge clk);
        @(negedge clk);
        check(host_rx, 1'h0);
        u_host.set_rx(1'h1);
        u_host.drive_rts(1'h0);
        $display("test request done");

        power_up(RDEC_MODE_DATA);
        pt = 1'h1;
        for (int i = 0; i < 8; i++)
        begin
            seed = rnd(seed);
            t = seed[2];
            u_host.drive_tx(t);
            settle(model_oe(RDEC_MODE_DATA, pt, 0) != 0, model_oe(RDEC_MODE_DATA, t, 0) != 0, t);
            pt = t;
        end
        u_host.drive_tx(1'h1);
        // a low enable freezes the pipeline while the pin moves
        repeat (6) @(posedge clk);
        ce <= 1'h0;
        u_host.drive_tx(1'h0);
        repeat (10) @(posedge clk);
        @(negedge clk);
        check(bus_oe, 1'h0);
        @(posedge clk);
        ce <= 1'h1;
        settle(1'h0, model_oe(RDEC_MODE_DATA, 0, 0) != 0, 1'h0);
        u_host.drive_tx(1'h1);
        $display("test data done");

        power_up(RDEC_MODE_AUTO);
        @(negedge clk);
        check(bus_oe, 1'h0);
        u_host.send_char(8'h55);
        @(negedge clk);
        check(bus_oe, 1'h1);
        wait_oe_low(3000, cnt);
        u_host.send_char(8'hff);
        @(negedge clk);
        check(bus_oe, 1'h1);
        wait_oe_low(40, cnt);
        check(cnt >= 3 && cnt <= 9, 1'h1);
        // remote node answers one bit time after the turnaround
        repeat (BITC) @(posedge clk);
        u_host.set_rx(1'h0);
        repeat (8) @(posedge clk);
        @(negedge clk);
        check(host_rx, 1'h0);
        u_host.set_rx(1'h1);
        $display("test auto done");
        stop_test();
    end
endmodule
`default_nettype wire
